// File: logic/spf_pkg.sv
// shared constants for the port framing control block
package spf_pkg;
  // ==========================================================
  // register map: word index, apb byte address is four times the index
  localparam logic [7:0] ADDR_LINE_UNIT_PLL_STATUS  = 8'h81;
  localparam logic [7:0] ADDR_OPTICAL_MODULE        = 8'h83;
  localparam logic [7:0] ADDR_PORT_CLOCK_ENABLE     = 8'h84;
  localparam logic [7:0] ADDR_RECEIVE_FRAMING       = 8'h85;
  localparam logic [7:0] ADDR_RECEIVE_FILTER        = 8'h86;
  localparam logic [7:0] ADDR_OUTPUT_DATA           = 8'h89;
  localparam logic [7:0] ADDR_FRAME_STATISTICS      = 8'h8B;
  localparam logic [7:0] ADDR_PARITY_ERROR_MASK     = 8'h8C;
  localparam logic [7:0] ADDR_FRAME_TAGGING         = 8'h8D;
  localparam logic [7:0] ADDR_FRAME_ERROR_COUNT     = 8'h90;

  // ==========================================================
  // field positions
  localparam int LINE_TX_LOCK_BIT     = 1;
  localparam int LINE_RX_LOCK_BIT     = 0;
  localparam int OPTIC_LOS_BIT        = 7;
  localparam int OPTIC_FAULT_BIT      = 6;
  localparam int OPTIC_PRESENT_BIT    = 5;
  localparam int OPTIC_TXDIS_BIT      = 0;
  localparam int EN_TX_LOCK_BIT       = 7;
  localparam int EN_RX_LOCK_BIT       = 6;
  localparam int EN_SYS_LOCK_BIT      = 5;
  localparam int EN_RX_RUN_BIT        = 4;
  localparam int EN_TX_RUN_BIT        = 1;
  localparam int EN_LINE_RUN_BIT      = 0;
  localparam int FR_LOCK_BIT          = 7;
  localparam int FR_BYTE_SYNC_BIT     = 6;
  localparam int FR_BIT_SYNC_BIT      = 5;
  localparam int FR_BYPASS_BIT        = 4;
  localparam int FR_FIFO_HI_BIT       = 3;
  localparam int FR_FIFO_LO_BIT       = 2;
  localparam int FR_GATED_BIT         = 1;
  localparam int FI_PRBS_PAYLOAD_BIT  = 3;
  localparam int FI_PAYLOAD_ONLY_BIT  = 2;
  localparam int FI_OVERHEAD_ONLY_BIT = 0;
  localparam int OD_TX_FIFO_BIT       = 5;
  localparam int OD_SOH_GEN_BIT       = 4;
  localparam int ST_ENABLE_BIT        = 7;
  localparam int ST_HOLD_BIT          = 0;
  localparam int TG_ENABLE_BIT        = 7;
  localparam int TG_SAVE_BIT          = 6;

  // ==========================================================
  // writable masks and reset values
  localparam logic [7:0] MASK_OPTICAL   = 8'h01;
  localparam logic [7:0] MASK_ENABLE    = 8'h13;
  localparam logic [7:0] MASK_FRAMING   = 8'h1E;
  localparam logic [7:0] MASK_FILTER    = 8'h0D;
  localparam logic [7:0] MASK_OUTPUT    = 8'h30;
  localparam logic [7:0] MASK_STATS     = 8'h81;
  localparam logic [7:0] MASK_TAGGING   = 8'hCF;
  localparam logic [7:0] RESET_CONTROL  = 8'h00;
  localparam logic [1:0] FIFO_BYPASS    = 2'h0;
  localparam logic [1:0] FIFO_ROUTE     = 2'h1;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
endpackage

// File: logic/spf_port_framing_control.sv
// control and status registers of one framed line port, apb slave
`timescale 1ns/1ps

// Behaviour
// [R1] line unit status: tx pll lock bit 1, rx pll lock bit 0, rest zero
// [R2] optic flags read only: loss bit 7, fault bit 6, present bit 5
// [R3] optic bit 0 set drives transmitter disable; clear re-enables light
// [R4] port enable reads tx lock bit 7, rx lock bit 6, system lock bit 5
// [R5] port enable bit 4 clear holds receive clock manager in reset
// [R6] port enable bit 1 clear holds transmit clock manager in reset
// [R7] port enable bit 0 clear holds line interface unit in reset
// [R8] software orders enables; enable high then low forces framer relock
// [R9] framing control bit 7 reports frame lock
// [R10] bit 6 reports byte-alignment pattern, bit 5 bit-alignment pattern
// [R11] bit 4 bypasses descrambling, effective only with bit 1 set
// [R12] bits 3-2 select receive fifo: 00 bypass, 01 route, 1x reserved
// [R13] bit 1 set passes data to acquisition only while framer locked
// [R14] filter bit 3 limits prbs checker to payload bytes
// [R15] filter bit 2 captures payload only, overhead dropped
// [R16] filter bit 0 captures overhead only while framing enabled
// [R17] output bit 5 sources transmit from fifo, bit 4 enables overhead generation
// [R18] statistics bit 7 enables error counters, clear holds them at zero
// [R19] statistics bit 0 freezes visible counter values for coherent reads
// [R20] parity mask register shows mask captured at most recent parity error
// [R21] tagging register has enable, keep-tagged control and tag identifier
// [R22] mask is computed parity xor received parity byte, kept when nonzero
// [R23] tag enable bit 7, save bit 6, identifier bits 3-0
module spf_port_framing_control
  import spf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_tx_pll_locked,
  input  wire logic        line_rx_pll_locked,
  input  wire logic        optic_signal_lost,
  input  wire logic        optic_transmit_fault,
  input  wire logic        optic_module_present,
  input  wire logic        tx_pll_locked,
  input  wire logic        rx_pll_locked,
  input  wire logic        system_pll_locked,
  input  wire logic        frame_locked,
  input  wire logic        byte_sync_found,
  input  wire logic        bit_sync_found,
  input  wire logic        rx_data_valid,
  input  wire logic        rx_is_overhead,
  input  wire logic        frame_error,
  input  wire logic        frame_end,
  input  wire logic        parity_check,
  input  wire logic [7:0]  parity_computed,
  input  wire logic [7:0]  parity_received,
  output logic             optic_transmit_disable,
  output logic             rx_clock_manager_run,
  output logic             tx_clock_manager_run,
  output logic             line_unit_run,
  output logic             framer_restart,
  output logic             descrambler_bypass,
  output logic [1:0]       rx_fifo_select,
  output logic             prbs_payload_only,
  output logic             capture_valid,
  output logic             tx_from_fifo,
  output logic             section_overhead_gen,
  output logic             tag_enable,
  output logic             tag_save,
  output logic [3:0]       tag_id
);
  import spf_pkg::*;

  // ==========================================================
  // control registers
  logic [7:0]  optical;
  logic [7:0]  enable;
  logic [7:0]  framing;
  logic [7:0]  filter;
  logic [7:0]  output_ctl;
  logic [7:0]  stats;
  logic [7:0]  tagging;
  logic [7:0]  parity_mask;
  logic [15:0] error_count;
  logic [15:0] error_view;
  logic [7:0]  next_optical;
  logic [7:0]  next_enable;
  logic [7:0]  next_framing;
  logic [7:0]  next_filter;
  logic [7:0]  next_output_ctl;
  logic [7:0]  next_stats;
  logic [7:0]  next_tagging;
  logic [7:0]  next_parity_mask;
  logic [15:0] next_error_count;
  logic [15:0] next_error_view;
  logic        wr;
  logic [7:0]  wbyte;
  logic [7:0]  parity_diff;
  logic [7:0]  word_index;

  // registers sit on aligned words; upper address bits alias the map
  assign word_index  = paddr[9:2];
  // two-cycle access phase, one wait state: write lands on the pready edge
  assign wr          = psel && penable && pwrite && pready && pstrb[0];
  assign wbyte       = pwdata[7:0];
  assign parity_diff = parity_computed ^ parity_received;

  always_comb begin
    next_optical    = optical;
    next_enable     = enable;
    next_framing    = framing;
    next_filter     = filter;
    next_output_ctl = output_ctl;
    next_stats      = stats;
    next_tagging    = tagging;
    if (wr) begin
      case (word_index)
        // [R3] transmitter disable
        ADDR_OPTICAL_MODULE:    next_optical    = wbyte & MASK_OPTICAL;
        ADDR_PORT_CLOCK_ENABLE: next_enable     = wbyte & MASK_ENABLE;
        // [R12] reserved fifo codes kept but treated as bypass
        ADDR_RECEIVE_FRAMING:   next_framing    = wbyte & MASK_FRAMING;
        ADDR_RECEIVE_FILTER:    next_filter     = wbyte & MASK_FILTER;
        ADDR_OUTPUT_DATA:       next_output_ctl = wbyte & MASK_OUTPUT;
        ADDR_FRAME_STATISTICS:  next_stats      = wbyte & MASK_STATS;
        // [R23] tagging layout
        ADDR_FRAME_TAGGING:     next_tagging    = wbyte & MASK_TAGGING;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      optical    <= RESET_CONTROL;
      enable     <= RESET_CONTROL;
      framing    <= RESET_CONTROL;
      filter     <= RESET_CONTROL;
      output_ctl <= RESET_CONTROL;
      stats      <= RESET_CONTROL;
      tagging    <= RESET_CONTROL;
    end else begin
      optical    <= next_optical;
      enable     <= next_enable;
      framing    <= next_framing;
      filter     <= next_filter;
      output_ctl <= next_output_ctl;
      stats      <= next_stats;
      tagging    <= next_tagging;
    end
  end

  // ==========================================================
  // parity mask and framing error counter
  always_comb begin
    next_parity_mask = parity_mask;
    next_error_count = error_count;
    next_error_view  = error_view;
    // [R22] capture only a nonzero difference
    if (parity_check && (parity_diff != 8'h00)) begin
      next_parity_mask = parity_diff;
    end
    // saturates, so a long error burst never reads back as a few
    // [R18] counters cleared while disabled
    if (!stats[ST_ENABLE_BIT]) begin
      next_error_count = COUNT_RESET;
    end else if (frame_error && (error_count != 16'hFFFF)) begin
      next_error_count = error_count + 16'h0001;
    end
    // [R19] visible copy frozen while holding
    if (!stats[ST_HOLD_BIT]) begin
      next_error_view = next_error_count;
    end else if (!stats[ST_ENABLE_BIT]) begin
      next_error_view = COUNT_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      parity_mask <= RESET_CONTROL;
      error_count <= COUNT_RESET;
      error_view  <= COUNT_RESET;
    end else begin
      parity_mask <= next_parity_mask;
      error_count <= next_error_count;
      error_view  <= next_error_view;
    end
  end

  // ==========================================================
  // apb read path and response
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  rbyte;
  logic        hit;

  always_comb begin
    rbyte = 8'h00;
    hit   = 1'b1;
    case (word_index)
      // [R1] line unit pll status
      ADDR_LINE_UNIT_PLL_STATUS: begin
        rbyte[LINE_TX_LOCK_BIT] = line_tx_pll_locked;
        rbyte[LINE_RX_LOCK_BIT] = line_rx_pll_locked;
      end
      // [R2] optic flags
      ADDR_OPTICAL_MODULE: begin
        rbyte                    = optical;
        rbyte[OPTIC_LOS_BIT]     = optic_signal_lost;
        rbyte[OPTIC_FAULT_BIT]   = optic_transmit_fault;
        rbyte[OPTIC_PRESENT_BIT] = optic_module_present;
      end
      // [R4] clock pll locks
      ADDR_PORT_CLOCK_ENABLE: begin
        rbyte                  = enable;
        rbyte[EN_TX_LOCK_BIT]  = tx_pll_locked;
        rbyte[EN_RX_LOCK_BIT]  = rx_pll_locked;
        rbyte[EN_SYS_LOCK_BIT] = system_pll_locked;
      end
      // [R9] [R10] framer state
      ADDR_RECEIVE_FRAMING: begin
        rbyte                   = framing;
        rbyte[FR_LOCK_BIT]      = frame_locked;
        rbyte[FR_BYTE_SYNC_BIT] = byte_sync_found;
        rbyte[FR_BIT_SYNC_BIT]  = bit_sync_found;
      end
      ADDR_RECEIVE_FILTER:    rbyte = filter;
      ADDR_OUTPUT_DATA:       rbyte = output_ctl;
      ADDR_FRAME_STATISTICS:  rbyte = stats;
      // [R20] parity mask readback
      ADDR_PARITY_ERROR_MASK: rbyte = parity_mask;
      ADDR_FRAME_TAGGING:     rbyte = tagging;
      ADDR_FRAME_ERROR_COUNT: rbyte = error_view[7:0];
      default:                hit   = 1'b0;
    endcase
  end

  always_comb begin
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    // answer one cycle into the access phase
    // unmapped index answers with pslverr and reads as zero
    if (psel && penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !hit;
      next_prdata  = pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
      if (!pwrite && word_index == ADDR_FRAME_ERROR_COUNT) begin
        next_prdata = {16'h0000, error_view};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // registered control outputs
  logic       prev_line_run;
  logic       next_prev_line_run;
  logic       next_capture_valid;
  logic       next_restart;
  logic       next_transmit_disable;
  logic       next_rx_run;
  logic       next_tx_run;
  logic       next_line_run;
  logic       next_bypass;
  logic [1:0] next_fifo_select;
  logic       next_prbs_payload;
  logic       next_tx_from_fifo;
  logic       next_overhead_gen;
  logic       next_tag_enable;
  logic       next_tag_save;
  logic [3:0] next_tag_id;

  always_comb begin
    next_prev_line_run = enable[EN_LINE_RUN_BIT];
    // [R8] falling enable drops lock and forces a new search
    next_restart = prev_line_run && !enable[EN_LINE_RUN_BIT];
    // capture lags the received byte by one cycle
    next_capture_valid = rx_data_valid;
    // [R13] acquisition gated by frame lock
    if (framing[FR_GATED_BIT] && !frame_locked) begin
      next_capture_valid = 1'b0;
    end
    // [R15] payload only
    if (filter[FI_PAYLOAD_ONLY_BIT] && rx_is_overhead) begin
      next_capture_valid = 1'b0;
    end
    // [R16] overhead only, needs framing enabled
    if (filter[FI_OVERHEAD_ONLY_BIT] && framing[FR_GATED_BIT] && !rx_is_overhead) begin
      next_capture_valid = 1'b0;
    end
  end

  // ==========================================================
  // control levels toward clock managers, optics and framer
  always_comb begin
    // outputs lag their register by one edge, keeping pins glitch free
    // [R3] light transmitter off
    next_transmit_disable = optical[OPTIC_TXDIS_BIT];
    // [R5] receive clock manager reset
    next_rx_run = enable[EN_RX_RUN_BIT];
    // [R6] transmit clock manager reset
    next_tx_run = enable[EN_TX_RUN_BIT];
    // [R7] line unit reset
    next_line_run = enable[EN_LINE_RUN_BIT];
    // [R11] bypass honoured only with gating
    next_bypass = framing[FR_BYPASS_BIT] && framing[FR_GATED_BIT];
    // [R12] reserved codes fall back to bypass
    next_fifo_select = framing[FR_FIFO_HI_BIT] ? FIFO_BYPASS : {1'b0, framing[FR_FIFO_LO_BIT]};
    // [R14] prbs checker scope
    next_prbs_payload = filter[FI_PRBS_PAYLOAD_BIT];
    // [R17] transmit source and overhead
    next_tx_from_fifo = output_ctl[OD_TX_FIFO_BIT];
    next_overhead_gen = output_ctl[OD_SOH_GEN_BIT];
    // [R21] tagging controls
    next_tag_enable = tagging[TG_ENABLE_BIT];
    next_tag_save = tagging[TG_SAVE_BIT];
    next_tag_id = tagging[3:0];
  end

  // all run levels low after reset: software brings the clocks up in order
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_line_run          <= 1'b0;
      framer_restart         <= 1'b0;
      capture_valid          <= 1'b0;
      optic_transmit_disable <= 1'b0;
      rx_clock_manager_run   <= 1'b0;
      tx_clock_manager_run   <= 1'b0;
      line_unit_run          <= 1'b0;
      descrambler_bypass     <= 1'b0;
      rx_fifo_select         <= FIFO_BYPASS;
      prbs_payload_only      <= 1'b0;
      tx_from_fifo           <= 1'b0;
      section_overhead_gen   <= 1'b0;
      tag_enable             <= 1'b0;
      tag_save               <= 1'b0;
      tag_id                 <= 4'h0;
    end else begin
      prev_line_run          <= next_prev_line_run;
      framer_restart         <= next_restart;
      capture_valid          <= next_capture_valid;
      optic_transmit_disable <= next_transmit_disable;
      rx_clock_manager_run   <= next_rx_run;
      tx_clock_manager_run   <= next_tx_run;
      line_unit_run          <= next_line_run;
      descrambler_bypass     <= next_bypass;
      rx_fifo_select         <= next_fifo_select;
      prbs_payload_only      <= next_prbs_payload;
      tx_from_fifo           <= next_tx_from_fifo;
      section_overhead_gen   <= next_overhead_gen;
      tag_enable             <= next_tag_enable;
      tag_save               <= next_tag_save;
      tag_id                 <= next_tag_id;
    end
  end
endmodule

// File: testbench/spf_framing_checker.sv
// assertions watching the ports of the port framing control block
`timescale 1ns/1ps
module spf_framing_checker
  import spf_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_data_valid,
  input wire logic        optic_transmit_disable,
  input wire logic        line_unit_run,
  input wire logic        framer_restart,
  input wire logic        capture_valid,
  input wire logic [1:0]  rx_fifo_select
);
  logic wr;
  logic wr_opt;
  logic wr_en;
  assign wr     = psel && penable && pready && pwrite && pstrb[0];
  assign wr_opt = wr && paddr[9:2] == ADDR_OPTICAL_MODULE;
  assign wr_en  = wr && paddr[9:2] == ADDR_PORT_CLOCK_ENABLE;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================================
  // bus answer
  ready_after_access_a: assert property (psel && penable && !pready |=> pready)
    else $error("no pready after access");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  error_has_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========================================================
  // control outputs
  txdis_follow_a: assert property (wr_opt |-> ##2 optic_transmit_disable == $past(pwdata[0], 2))
    else $error("transmit disable not following write");
  line_run_follow_a: assert property (wr_en |-> ##2 line_unit_run == $past(pwdata[0], 2))
    else $error("line run not following write");
  restart_on_fall_a: assert property (wr_en && !pwdata[0] && line_unit_run |-> ##[1:3] framer_restart)
    else $error("no restart after line enable fell");
  restart_pulse_a: assert property (framer_restart |=> !framer_restart)
    else $error("restart longer than one cycle");
  capture_source_a: assert property (capture_valid |-> $past(rx_data_valid))
    else $error("capture without received byte");
  fifo_reserved_a: assert property (!rx_fifo_select[1])
    else $error("reserved fifo code driven");
  cover property (wr_opt);
  cover property (framer_restart);
  cover property (pslverr);
endmodule

// File: testbench/spf_line_model.sv
// line side partner: framer lock and received byte stream
`timescale 1ns/1ps
module spf_line_model (
  input  wire logic clock,
  input  wire logic line_unit_run,
  input  wire logic framer_restart,
  output logic      frame_locked,
  output logic      rx_data_valid,
  output logic      rx_is_overhead
);
  logic [2:0] hunt;
  logic [1:0] col;
  initial begin
    hunt = 3'h0;
    col = 2'h0;
    frame_locked = 1'b0;
    rx_data_valid = 1'b0;
    rx_is_overhead = 1'b0;
  end
  always @(posedge clock) begin
    if (!line_unit_run || framer_restart) begin
      hunt <= 3'h0;
    end else if (hunt != 3'h7) begin
      hunt <= hunt + 3'h1;
    end
    frame_locked <= hunt == 3'h7 && line_unit_run && !framer_restart;
    col <= col + 2'h1;
    rx_data_valid <= col != 2'h3;
    rx_is_overhead <= col == 2'h0;
  end
endmodule

// File: testbench/sdh_port_framing_control_tb.sv
// self-checking bench for the port framing control block
`timescale 1ns/1ps
module sdh_port_framing_control_tb import spf_pkg::*;;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr;
  logic        frame_error, parity_check, e, lock, dv, ov, seen;
  logic        txd, rxr, txr, lur, rst, byp, ppo, cap, tff, sog, tge, tgs;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [9:0]  st;
  logic [7:0]  pc, pr, m, x, y;
  logic [7:0]  wa [7];
  logic [7:0]  wm [7];
  logic [7:0]  v [7];
  logic [1:0]  fsel;
  logic [3:0]  tid;
  logic [15:0] cnt;
  integer      seed = 32'h030552fd;
  int          fails = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;

  spf_port_framing_control i_spf_port_framing_control (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_tx_pll_locked(st[9]), .line_rx_pll_locked(st[8]), .optic_signal_lost(st[7]),
    .optic_transmit_fault(st[6]), .optic_module_present(st[5]), .tx_pll_locked(st[4]),
    .rx_pll_locked(st[3]), .system_pll_locked(st[2]), .frame_locked(lock), .byte_sync_found(st[1]),
    .bit_sync_found(st[0]), .rx_data_valid(dv), .rx_is_overhead(ov), .frame_error(frame_error),
    .frame_end(1'b0), .parity_check(parity_check), .parity_computed(pc), .parity_received(pr),
    .optic_transmit_disable(txd), .rx_clock_manager_run(rxr), .tx_clock_manager_run(txr),
    .line_unit_run(lur), .framer_restart(rst), .descrambler_bypass(byp), .rx_fifo_select(fsel),
    .prbs_payload_only(ppo), .capture_valid(cap), .tx_from_fifo(tff), .section_overhead_gen(sog),
    .tag_enable(tge), .tag_save(tgs), .tag_id(tid)
  );
  spf_line_model i_spf_line_model (
    .clock(clock), .line_unit_run(lur), .framer_restart(rst),
    .frame_locked(lock), .rx_data_valid(dv), .rx_is_overhead(ov)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      results();
    end
  end

  task chk(input string s, input logic [31:0] xp, input logic [31:0] g);
    checks = checks + 1;
    if (g !== xp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", s, xp, g);
    end
  endtask

  // master holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [15:0] xp);
    apb(1'b0, a, 8'h00);
    chk("read data", {16'h0, xp}, r);
  endtask

  task endt(input string s);
    $display("test %s done", s);
  endtask

  task errs(input int c);
    frame_error <= 1'b1;
    repeat (c) @(posedge clock);
    frame_error <= 1'b0;
    @(posedge clock);
  endtask

  task capchk(input logic g, input logic [1:0] f);
    logic pv, po, pl;
    @(posedge clock);
    repeat (8) begin
      pv = dv;
      po = ov;
      pl = lock;
      @(posedge clock);
      chk("capture", {31'h0, pv & (!g | pl) & (!f[0] | po) & (!f[1] | !po)}, {31'h0, cap});
    end
  endtask

  function logic [7:0] stat(input logic [7:0] a);
    case (a)
      ADDR_LINE_UNIT_PLL_STATUS: stat = {6'h00, st[9:8]};
      ADDR_OPTICAL_MODULE:       stat = {st[7:5], 5'h00};
      ADDR_PORT_CLOCK_ENABLE:    stat = {st[4:2], 5'h00};
      ADDR_RECEIVE_FRAMING:      stat = {lock, st[1:0], 5'h00};
      default:                   stat = 8'h00;
    endcase
  endfunction

  // reserved fifo codes drive bypass; descrambler bypass needs gating
  function logic [15:0] outs();
    outs = {v[0][0], v[1][4], v[1][1], v[1][0], v[2][4] & v[2][1], v[2][3] ? 2'h0 : v[2][3:2],
            v[3][3], v[4][5], v[4][4], v[6][7], v[6][6], v[6][3:0]};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    reset <= 1'b1;
    {psel, penable, pwrite, frame_error, parity_check} <= 5'h00;
    {paddr, pwdata} <= 64'h0;
    {st, pc, pr} <= 26'h0;
    wa = '{ADDR_OPTICAL_MODULE, ADDR_PORT_CLOCK_ENABLE, ADDR_RECEIVE_FRAMING, ADDR_RECEIVE_FILTER,
           ADDR_OUTPUT_DATA, ADDR_FRAME_STATISTICS, ADDR_FRAME_TAGGING};
    wm = '{MASK_OPTICAL, MASK_ENABLE, MASK_FRAMING, MASK_FILTER, MASK_OUTPUT, MASK_STATS, MASK_TAGGING};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    st <= 10'($random(seed));
    @(posedge clock);
    for (int i = 0; i < 7; i++) rd(wa[i], {8'h00, stat(wa[i])});
    rd(ADDR_LINE_UNIT_PLL_STATUS, {8'h00, stat(ADDR_LINE_UNIT_PLL_STATUS)});
    rd(ADDR_PARITY_ERROR_MASK, 16'h0000);
    apb(1'b0, 8'h82, 8'h00);
    chk("unmapped", 32'h1, {31'h0, e});
    endt("reset");
    for (int k = 0; k < 4; k++) begin
      st <= 10'($random(seed));
      for (int i = 0; i < 7; i++) begin
        v[i] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
        wr(wa[i], v[i]);
      end
      repeat (10) @(posedge clock);
      chk("outputs", {16'h0, outs()}, {16'h0, txd, rxr, txr, lur, byp, fsel, ppo, tff, sog, tge, tgs, tid});
      for (int i = 0; i < 7; i++) rd(wa[i], {8'h00, (v[i] & wm[i]) | stat(wa[i])});
    end
    endt("registers");
    wr(ADDR_PORT_CLOCK_ENABLE, 8'h00);
    wr(ADDR_RECEIVE_FILTER, 8'h00);
    wr(ADDR_RECEIVE_FRAMING, 8'h02);
    capchk(1'b1, 2'h0);
    wr(ADDR_PORT_CLOCK_ENABLE, 8'h01);
    repeat (10) @(posedge clock);
    capchk(1'b1, 2'h0);
    wr(ADDR_RECEIVE_FILTER, 8'h01);
    capchk(1'b1, 2'h1);
    wr(ADDR_RECEIVE_FILTER, 8'h04);
    capchk(1'b1, 2'h2);
    wr(ADDR_RECEIVE_FILTER, 8'h01);
    wr(ADDR_RECEIVE_FRAMING, 8'h00);
    capchk(1'b0, 2'h0);
    endt("capture");
    wr(ADDR_PORT_CLOCK_ENABLE, 8'h13);
    repeat (10) @(posedge clock);
    wr(ADDR_PORT_CLOCK_ENABLE, 8'h12);
    seen = 1'b0;
    repeat (4) @(posedge clock) seen = seen | rst;
    chk("restart", 32'h1, {31'h0, seen});
    chk("run bits", 32'h6, {29'h0, rxr, txr, lur});
    endt("restart");
    wr(ADDR_FRAME_STATISTICS, 8'h00);
    wr(ADDR_FRAME_STATISTICS, 8'h80);
    n = ($random(seed) & 7) + 1;
    cnt = 16'(n);
    errs(n);
    rd(ADDR_FRAME_ERROR_COUNT, cnt);
    wr(ADDR_FRAME_STATISTICS, 8'h81);
    errs(3);
    rd(ADDR_FRAME_ERROR_COUNT, cnt);
    wr(ADDR_FRAME_STATISTICS, 8'h80);
    rd(ADDR_FRAME_ERROR_COUNT, cnt + 16'h3);
    wr(ADDR_FRAME_STATISTICS, 8'h00);
    errs(2);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0);
    endt("counters");
    m = 8'h00;
    for (int k = 0; k < 4; k++) begin
      x = 8'($random(seed));
      y = (k == 2) ? x : 8'($random(seed));
      pc <= x;
      pr <= y;
      parity_check <= 1'b1;
      @(posedge clock);
      parity_check <= 1'b0;
      if ((x ^ y) != 8'h00) m = x ^ y;
      rd(ADDR_PARITY_ERROR_MASK, {8'h00, m});
    end
    endt("parity");
    results();
  end
endmodule

bind spf_port_framing_control spf_framing_checker i_spf_framing_checker (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .rx_data_valid(rx_data_valid), .optic_transmit_disable(optic_transmit_disable),
  .line_unit_run(line_unit_run), .framer_restart(framer_restart),
  .capture_valid(capture_valid), .rx_fifo_select(rx_fifo_select)
);
